// File: dv/ssl_host_mem.sv
// Host controller memory model on the far side of the link engine.
// Assumes one held request at a time; the bench pokes words directly.
`timescale 1ns/1ps
module ssl_host_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request side
  input wire logic req_valid,
  input wire ssl_pkg::ssl_hreq_t req,
  input wire logic [3:0] dly,
  output logic ack,
  output logic [ssl_pkg::WORD_W-1:0] rdata
);
  import ssl_pkg::*;
  logic [WORD_W-1:0] mem [0:65535];
  logic [WORD_W-1:0] last_q;
  logic [3:0] cnt_q;
  // All words start clear
  initial begin
    for (int a = 0; a < 65536; a++) mem[a] = 16'h0000;
  end
  // Ack after dly stall cycles, so slow scans are exercised too
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
      cnt_q <= 4'h0;
    end else if (ack || !req_valid) begin
      ack <= 1'b0;
      cnt_q <= 4'h0;
    end else if (cnt_q >= dly) begin
      ack <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // Word update and read capture at the take edge
  always @(posedge clk) begin
    if (ack && req_valid && req.we) mem[req.addr] <= req.wdata;
    if (ack && req_valid) last_q <= mem[req.addr];
  end
  // Read data only valid with ack; otherwise the inverse of the last word taken
  assign rdata = ack ? mem[req.addr] : ~last_q;
endmodule

// File: dv/ssl_link_assertions.sv
// Concurrent checks on the link engine's ports.
// Assumes the single clock domain of ssl_link; bound below.
`timescale 1ns/1ps
module ssl_link_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Watched ports
  input wire logic [ssl_pkg::ADDR_W-1:0] notify_base,
  input wire logic notify_rd,
  input wire logic hm_req_valid,
  input wire ssl_pkg::ssl_hreq_t hm_req,
  input wire logic hm_ack,
  input wire logic [ssl_pkg::WORD_W-1:0] hm_rdata,
  input wire logic disp_valid,
  input wire ssl_pkg::ssl_disp_t disp,
  input wire logic strobe_flag,
  input wire logic screen_blank
);
  import ssl_pkg::*;
  logic take, to_scr, to_sts, rd_q;
  logic [10:0] hold_q;
  // Taken writes to the two notify words
  assign take = hm_req_valid && hm_ack && hm_req.we;
  assign to_scr = take && hm_req.addr == notify_base + SCREEN_OFS;
  assign to_sts = take && hm_req.addr == notify_base + STATUS_OFS;
  // Cycles the strobe stood; saturates so it never wraps
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) hold_q <= 11'h000;
    else if (!strobe_flag) hold_q <= 11'h000;
    else if (hold_q != 11'h7ff) hold_q <= hold_q + 11'h001;
  end
  // Host read seen while the strobe stood
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rd_q <= 1'b0;
    else if (!strobe_flag) rd_q <= 1'b0;
    else if (notify_rd) rd_q <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  req_hold_a: assert property (hm_req_valid && !hm_ack
    |=> hm_req_valid && $stable(hm_req))
    else $error("host request changed before ack");
  req_drop_a: assert property (hm_req_valid && hm_ack |=> !hm_req_valid)
    else $error("host request held after ack");
  scr_bcd_a: assert property (to_scr |->
    hm_req.wdata[3:0] <= 4'h9 && hm_req.wdata[7:4] <= 4'h9
    && hm_req.wdata[11:8] <= 4'h9 && hm_req.wdata[15:12] <= 4'h9)
    else $error("screen word not decimal digits");
  strobe_set_a: assert property (
    to_sts && hm_req.wdata == STROBE_MASK |-> ##[0:2] strobe_flag)
    else $error("strobe write without strobe flag");
  strobe_clr_a: assert property (
    to_sts && hm_req.wdata == 16'h0000 |-> ##[0:2] !strobe_flag)
    else $error("status clear with strobe still set");
  clr_after_rd_a: assert property ($fell(strobe_flag) |-> $past(rd_q))
    else $error("strobe cleared before host read");
  strobe_hold_a: assert property (
    $fell(strobe_flag) |-> hold_q >= STROBE_HOLD_CYC - 1)
    else $error("strobe cleared too early");
  blank_flag_a: assert property (to_scr |-> ##3
    screen_blank == ($past(hm_req.wdata, 3) == 16'h0000))
    else $error("blank flag disagrees with screen word");
  // Ack is taken two edges before the display pulse is sampled
  disp_data_a: assert property (disp_valid |->
    $past(hm_ack, 2) && disp.data == $past(hm_rdata, 2))
    else $error("display word not the host word");
endmodule

bind ssl_link ssl_link_assertions u_chk (
  .clk(clk), .rstn(rstn), .notify_base(notify_base),
  .notify_rd(notify_rd), .hm_req_valid(hm_req_valid), .hm_req(hm_req),
  .hm_ack(hm_ack), .hm_rdata(hm_rdata), .disp_valid(disp_valid),
  .disp(disp), .strobe_flag(strobe_flag), .screen_blank(screen_blank)
);

// File: dv/ssl_link_test.sv
// Self-checking bench for the screen status and table link engine.
// Assumes ssl_host_mem stands on the host memory port.
`timescale 1ns/1ps
module ssl_link_test;
  import ssl_pkg::*;
  logic clk, rstn, cfg_we, data_ready, link_v5, scr_chg, notify_rd;
  logic hm_req_valid, hm_ack, disp_valid, strobe_flag, screen_blank;
  logic ind_overflow, init_done;
  logic [7:0] cfg_addr;
  logic [31:0] cfg_wdata;
  logic [15:0] hm_rdata;
  logic [3:0] dly;
  ssl_scr_t scr;
  ssl_hreq_t hm_req;
  ssl_disp_t disp;
  int n_mismatch, checks_done;
  int dc [128];
  logic [15:0] dd [128];
  ssl_kind_t dk [128];
  logic [3:0] mx [128];
  // Notify area 0x0100, string 0x1000, numeral 0x2000
  ssl_link dut (.clk(clk), .rstn(rstn), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .data_ready(data_ready),
    .link_v5(link_v5), .notify_base(16'h0100), .str_base(16'h1000),
    .num_base(16'h2000), .scr_chg(scr_chg), .scr(scr),
    .notify_rd(notify_rd), .hm_req_valid(hm_req_valid), .hm_req(hm_req),
    .hm_ack(hm_ack), .hm_rdata(hm_rdata), .disp_valid(disp_valid),
    .disp(disp), .strobe_flag(strobe_flag), .screen_blank(screen_blank),
    .ind_overflow(ind_overflow), .init_done(init_done));
  ssl_host_mem host (.clk(clk), .rstn(rstn), .req_valid(hm_req_valid),
    .req(hm_req), .dly(dly), .ack(hm_ack), .rdata(hm_rdata));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Latest word zero, count and top word index per display item
  always @(posedge clk) begin
    if (disp_valid === 1'b1) begin
      if (disp.widx === 4'h0) begin
        dd[disp.item] <= disp.data;
        dk[disp.item] <= disp.kind;
        dc[disp.item] <= dc[disp.item] + 1;
      end
      if (disp.widx > mx[disp.item]) mx[disp.item] <= disp.widx;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    cfg_we = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_we = 1'b0;
  endtask
  function automatic logic [31:0] it(ssl_kind_t k, logic ind,
    logic [7:0] t, logic [4:0] w, logic [5:0] g);
    it = {1'b1, k, ind, t, w, g, 9'h000};
  endfunction
  // Two fresh reads of an item, so a host change has surely been seen
  task automatic wait_disp(input int i, input ssl_kind_t k,
    input logic [15:0] e);
    int n0;
    n0 = dc[i];
    for (int c = 0; c < 8000 && dc[i] < n0 + 2; c++) @(negedge clk);
    // A refresh that never came counts as a mismatch
    chk(dc[i] >= n0 + 2, 1'b1);
    chk({dk[i], dd[i]}, {k, e});
  endtask
  task automatic t_reset();
    repeat (15) @(negedge clk);
    chk({hm_req_valid, disp_valid, strobe_flag, screen_blank,
      ind_overflow, init_done}, 6'b000100);
    @(negedge clk);
    rstn = 1'b1;
  endtask
  task automatic t_init();
    host.mem[16'h2008] = 16'h1234;
    host.mem[16'h200c] = 16'h0009;
    host.mem[16'h2012] = 16'h5678;
    host.mem[16'h200e] = 16'h0777;
    host.mem[16'h1090] = 16'h4142;
    host.mem[16'h1060] = 16'h5859;
    for (int a = 0; a < 256; a++) cfg(a[7:0], 32'h0);
    cfg(8'h00, it(SSL_K_NUM, 1'b0, 8'h04, 5'h01, 6'h04));
    cfg(8'h01, it(SSL_K_STR, 1'b1, 8'h06, 5'h01, 6'h02));
    cfg(8'h02, it(SSL_K_NUM, 1'b1, 8'h06, 5'h01, 6'h04));
    cfg(8'h03, it(SSL_K_BAR, 1'b1, 8'h07, 5'h01, 6'h04));
    // Items 4..53 bring the indirect numerals to 51, one too many
    for (int a = 4; a < 54; a++)
      cfg(a[7:0], it(SSL_K_NUM, 1'b1, 8'h06, 5'h01, 6'h04));
    cfg(8'h36, it(SSL_K_STR, 1'b0, 8'h02, 5'h10, 6'h06));
    // Over-long string and widest digit field: clamp to sixteen words
    cfg(8'h37, it(SSL_K_STR, 1'b0, 8'h01, 5'h1f, 6'h3f));
    // Entry table marked indirect must still read its own words
    cfg(8'h38, it(SSL_K_ENTRY, 1'b1, 8'h07, 5'h01, 6'h04));
    cfg(8'h80, {1'b1, 1'b1, 8'h03, 4'h2, 2'h0, 16'h4142});
    cfg(8'h81, {1'b1, 1'b0, 8'h05, 4'h1, 2'h0, 16'h0099});
    @(negedge clk);
    data_ready = 1'b1;
    for (int c = 0; c < 3000 && init_done !== 1'b1; c++) @(negedge clk);
    chk(init_done, 1'b1);
    chk(host.mem[16'h1032], 16'h4142);
    chk(host.mem[16'h200b], 16'h0099);
    chk(host.mem[16'h1033], 16'h0000);
  endtask
  task automatic t_screen(input logic [15:0] n, input logic [15:0] p,
    input logic g, input logic [15:0] e);
    @(negedge clk);
    scr = '{number: n, parent: p, grouped: g};
    scr_chg = 1'b1;
    @(negedge clk);
    scr_chg = 1'b0;
    for (int c = 0; c < 400 && strobe_flag !== 1'b1; c++) @(negedge clk);
    repeat (8) @(negedge clk);
    chk(host.mem[16'h0100], e);
    chk(host.mem[16'h0102], 16'h8000);
    chk(screen_blank, e == 16'h0000);
    // Host has read the screen word on the flag; it reports so
    notify_rd = 1'b1;
    @(negedge clk);
    notify_rd = 1'b0;
    repeat (900) @(negedge clk);
    chk(strobe_flag, 1'b1);
    for (int c = 0; c < 400 && strobe_flag !== 1'b0; c++) @(negedge clk);
    repeat (8) @(negedge clk);
    chk(host.mem[16'h0102], 16'h0000);
  endtask
  task automatic t_display();
    wait_disp(0, SSL_K_NUM, 16'h1234);
    wait_disp(1, SSL_K_STR, 16'h4142);
    wait_disp(2, SSL_K_NUM, 16'h5678);
    wait_disp(3, SSL_K_BAR, 16'h0777);
    wait_disp(56, SSL_K_ENTRY, 16'h0777);
    wait_disp(52, SSL_K_NUM, 16'h5678);
    chk(dc[53], 0);
    chk(ind_overflow, 1'b1);
    chk(mx[54], 4'h2);
    chk(mx[55], 4'hf);
    host.mem[16'h2008] = 16'h4321;
    host.mem[16'h1090] = 16'h4344;
    dly = 4'h3;
    wait_disp(0, SSL_K_NUM, 16'h4321);
    wait_disp(1, SSL_K_STR, 16'h4344);
  endtask
  task automatic t_fallback();
    @(negedge clk);
    link_v5 = 1'b0;
    wait_disp(1, SSL_K_STR, 16'h5859);
    wait_disp(2, SSL_K_NUM, 16'h0009);
  endtask
  // Main sequence
  initial begin
    rstn = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0;
    data_ready = 1'b0;
    link_v5 = 1'b1;
    scr_chg = 1'b0;
    scr = '0;
    notify_rd = 1'b0;
    dly = 4'h0;
    n_mismatch = 0;
    checks_done = 0;
    foreach (mx[i]) mx[i] = 4'h0;
    t_reset();
    t_init();
    t_screen(16'h0012, 16'h0000, 1'b0, 16'h0012);
    t_display();
    t_fallback();
    t_screen(16'h0021, 16'h0020, 1'b1, 16'h0020);
    t_screen(16'h0000, 16'h0000, 1'b0, 16'h0000);
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule

// File: hw/ssl_link.sv
// Screen status notify and memory table refresh engine of the terminal.
// Assumes a host memory port with a held request and a one-cycle ack,
// and that screen data are loaded before data_ready goes high.
`timescale 1ns/1ps

// How it works
// - Screen numbers travel as four BCD digits
// - New screen word write sets strobe flag
// - Strobe flag cleared after host notified
// - Local and host screen changes both reported
// - Grouped screens report parent screen number
// - Screen number zero means blank screen
// - Shown strings track allocated host words
// - Direct reference shows allocated words exactly
// - Indirect reference only on version five link
// - Indirect string: numeral value selects string table
// - Indirect numeral: numeral value selects table
// - At most fifty indirect numerals, strings per screen
// - Reset writes initial values into host words
// - String table at most sixteen words
// - Strings longer than digits may truncate
// - Numeral displays track allocated host words
// - Bar graph drawn from its table value
// - Graph and entry tables direct only
module ssl_link (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Screen data loader and configuration
  input wire logic cfg_we,
  input wire logic [ssl_pkg::RAM_AW-1:0] cfg_addr,
  input wire logic [ssl_pkg::RAM_DW-1:0] cfg_wdata,
  input wire logic data_ready,
  input wire logic link_v5,
  input wire logic [ssl_pkg::ADDR_W-1:0] notify_base,
  input wire logic [ssl_pkg::ADDR_W-1:0] str_base,
  input wire logic [ssl_pkg::ADDR_W-1:0] num_base,
  // Screen changes, local or host driven
  input wire logic scr_chg,
  input wire ssl_pkg::ssl_scr_t scr,
  input wire logic notify_rd,
  // Host memory port
  output logic hm_req_valid,
  output ssl_pkg::ssl_hreq_t hm_req,
  input wire logic hm_ack,
  input wire logic [ssl_pkg::WORD_W-1:0] hm_rdata,
  // Display side and status
  output logic disp_valid,
  output ssl_pkg::ssl_disp_t disp,
  output logic strobe_flag,
  output logic screen_blank,
  output logic ind_overflow,
  output logic init_done
);
  import ssl_pkg::*;

  typedef enum logic [3:0] {
    ST_BOOT,
    ST_INIT_RD,
    ST_INIT_CHK,
    ST_INIT_NEXT,
    ST_HOST,
    ST_IDLE,
    ST_STROBE_SET,
    ST_ITEM_RD,
    ST_ITEM_CHK,
    ST_IND_DONE,
    ST_WORD,
    ST_SHOW,
    ST_NEXT
  } ssl_state_t;

  ssl_state_t state_q;
  ssl_state_t ret_q;
  logic [ITEM_W-1:0] item_idx_q;
  logic [ITEM_W-1:0] init_idx_q;
  ssl_item_t item_q;
  logic [3:0] widx_q;
  logic [4:0] nwords_q;
  logic [TAB_W-1:0] tgt_tab_q;
  logic tgt_str_q;
  logic [5:0] ind_num_cnt_q;
  logic [5:0] ind_str_cnt_q;
  logic [WORD_W-1:0] rd_q;
  logic scr_pend_q;
  logic [WORD_W-1:0] scr_num_q;
  logic seen_q;
  logic [HOLD_W-1:0] hold_q;
  logic ram_re;
  logic [RAM_AW-1:0] ram_raddr;
  logic [RAM_DW-1:0] ram_rdata;
  ssl_item_t it;
  ssl_init_t ini;
  logic scr_take;
  logic strobe_set;
  logic strobe_clr;
  logic clear_due;
  logic want_ind;
  logic ind_room;
  logic [4:0] str_words;
  logic [5:0] digit_words;

  // Host word address of a table word
  function automatic logic [ADDR_W-1:0] tab_addr(
    input logic is_str,
    input logic [TAB_W-1:0] tab,
    input logic [3:0] widx
  );
    logic [ADDR_W-1:0] a;
    if (is_str) begin
      a = str_base + {4'h0, tab, 4'h0};
    end else begin
      a = num_base + {7'h00, tab, 1'b0};
    end
    return a + {12'h000, widx};
  endfunction

  // Four BCD digits to a table number; out-of-range numbers wrap
  function automatic logic [TAB_W-1:0] bcd_to_tab(
    input logic [WORD_W-1:0] v
  );
    logic [13:0] b;
    b = 14'(v[15:12]) * 14'd1000 + 14'(v[11:8]) * 14'd100
      + 14'(v[7:4]) * 14'd10 + 14'(v[3:0]);
    return b[TAB_W-1:0];
  endfunction

  ssl_tab_ram u_ram (
    .clk(clk),
    .rstn(rstn),
    .we(cfg_we),
    .waddr(cfg_addr),
    .wdata(cfg_wdata),
    .re(ram_re),
    .raddr(ram_raddr),
    .rdata_q(ram_rdata)
  );

  // Memory read steering; init records sit in the upper half
  always_comb begin
    ram_re = (state_q == ST_INIT_RD) || (state_q == ST_ITEM_RD);
    if (state_q == ST_INIT_RD) begin
      ram_raddr = {1'b1, init_idx_q};
    end else begin
      ram_raddr = {1'b0, item_idx_q};
    end
  end

  // Item decode; length clamps and indirect admission
  always_comb begin
    it = ssl_item_t'(ram_rdata);
    ini = ssl_init_t'(ram_rdata);
    str_words = (it.words > STR_MAX_WORDS) ? STR_MAX_WORDS : it.words;
    // Widened so a 63-digit field cannot wrap to zero words
    digit_words = 6'(({1'b0, it.digits} + 7'h01) >> 1);
    if ({1'b0, str_words} > digit_words) begin
      str_words = 5'(digit_words);
    end
    // Graph and entry tables never go indirect
    want_ind = it.indirect && link_v5
      && (it.kind == SSL_K_STR || it.kind == SSL_K_NUM);
    if (it.kind == SSL_K_STR) begin
      ind_room = ind_str_cnt_q < IND_MAX;
    end else begin
      ind_room = ind_num_cnt_q < IND_MAX;
    end
  end

  // Dispatch decisions taken from idle; strobe set taken in ST_STROBE_SET
  always_comb begin
    clear_due = strobe_flag && seen_q
      && (hold_q == HOLD_W'(STROBE_HOLD_CYC));
    scr_take = (state_q == ST_IDLE) && scr_pend_q;
    strobe_set = (state_q == ST_STROBE_SET);
    strobe_clr = (state_q == ST_IDLE) && !scr_pend_q && clear_due;
  end

  // Pending screen report; a new change wins over the take
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scr_pend_q <= 1'b0;
      scr_num_q <= BLANK_SCREEN;
    end else if (scr_chg) begin
      scr_pend_q <= 1'b1;
      scr_num_q <= scr.grouped ? scr.parent : scr.number;
    end else if (scr_take) begin
      scr_pend_q <= 1'b0;
    end
  end

  // Strobe flag, host-read tracking and hold timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_flag <= 1'b0;
      seen_q <= 1'b0;
      hold_q <= '0;
    end else if (strobe_set) begin
      strobe_flag <= 1'b1;
      seen_q <= 1'b0;
      hold_q <= '0;
    end else if (strobe_clr) begin
      strobe_flag <= 1'b0;
    end else if (strobe_flag) begin
      // Host only sees the flag once a full read has passed
      if (notify_rd) begin
        seen_q <= 1'b1;
      end
      if (hold_q != HOLD_W'(STROBE_HOLD_CYC)) begin
        hold_q <= hold_q + 1'b1;
      end
    end
  end

  // Blank screen indication follows the reported number
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      screen_blank <= 1'b1;
    end else if (scr_take) begin
      screen_blank <= (scr_num_q == BLANK_SCREEN);
    end
  end

  // Main sequencer: init, notify writes, table refresh walk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_BOOT;
      ret_q <= ST_IDLE;
      item_idx_q <= '0;
      init_idx_q <= '0;
      item_q <= '0;
      widx_q <= 4'h0;
      nwords_q <= 5'h00;
      tgt_tab_q <= '0;
      tgt_str_q <= 1'b0;
      ind_num_cnt_q <= 6'h00;
      ind_str_cnt_q <= 6'h00;
      rd_q <= 16'h0000;
      hm_req_valid <= 1'b0;
      hm_req <= '0;
      disp_valid <= 1'b0;
      disp <= '0;
      ind_overflow <= 1'b0;
      init_done <= 1'b0;
    end else begin
      disp_valid <= 1'b0;
      case (state_q)
        ST_BOOT: begin
          if (data_ready) begin
            state_q <= ST_INIT_RD;
          end
        end
        ST_INIT_RD: begin
          state_q <= ST_INIT_CHK;
        end
        ST_INIT_CHK: begin
          // Only tables marked for init get their host words written
          if (ini.valid) begin
            hm_req <= '{we: 1'b1,
              addr: tab_addr(ini.is_str, ini.table_no, ini.widx),
              wdata: ini.value};
            hm_req_valid <= 1'b1;
            ret_q <= ST_INIT_NEXT;
            state_q <= ST_HOST;
          end else begin
            state_q <= ST_INIT_NEXT;
          end
        end
        ST_INIT_NEXT: begin
          if (init_idx_q == ITEM_LAST) begin
            init_done <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            init_idx_q <= init_idx_q + 1'b1;
            state_q <= ST_INIT_RD;
          end
        end
        ST_HOST: begin
          // Request stays up until the host memory acknowledges
          if (hm_ack) begin
            hm_req_valid <= 1'b0;
            rd_q <= hm_rdata;
            state_q <= ret_q;
          end
        end
        ST_IDLE: begin
          if (scr_pend_q) begin
            // New screen restarts the walk and the indirect budget
            hm_req <= '{we: 1'b1, addr: notify_base + SCREEN_OFS,
              wdata: scr_num_q};
            hm_req_valid <= 1'b1;
            ret_q <= ST_STROBE_SET;
            state_q <= ST_HOST;
            item_idx_q <= '0;
            ind_num_cnt_q <= 6'h00;
            ind_str_cnt_q <= 6'h00;
          end else if (clear_due) begin
            hm_req <= '{we: 1'b1, addr: notify_base + STATUS_OFS,
              wdata: 16'h0000};
            hm_req_valid <= 1'b1;
            ret_q <= ST_IDLE;
            state_q <= ST_HOST;
          end else if (init_done) begin
            state_q <= ST_ITEM_RD;
          end
        end
        ST_STROBE_SET: begin
          // Status write follows the screen word straight away
          hm_req <= '{we: 1'b1, addr: notify_base + STATUS_OFS,
            wdata: STROBE_MASK};
          hm_req_valid <= 1'b1;
          ret_q <= ST_IDLE;
          state_q <= ST_HOST;
        end
        ST_ITEM_RD: begin
          state_q <= ST_ITEM_CHK;
        end
        ST_ITEM_CHK: begin
          item_q <= it;
          widx_q <= 4'h0;
          tgt_str_q <= (it.kind == SSL_K_STR);
          if (it.kind == SSL_K_STR) begin
            nwords_q <= str_words;
          end else begin
            nwords_q <= (it.words > NUM_MAX_WORDS) ? NUM_MAX_WORDS : it.words;
          end
          if (!it.valid || it.words == 5'h00) begin
            state_q <= ST_NEXT;
          end else if (want_ind && !ind_room) begin
            ind_overflow <= 1'b1;
            state_q <= ST_NEXT;
          end else if (want_ind) begin
            // Slower path: extra host read for the selector table
            if (it.kind == SSL_K_STR) begin
              ind_str_cnt_q <= ind_str_cnt_q + 1'b1;
            end else begin
              ind_num_cnt_q <= ind_num_cnt_q + 1'b1;
            end
            hm_req <= '{we: 1'b0, addr: tab_addr(1'b0, it.table_no, 4'h0),
              wdata: 16'h0000};
            hm_req_valid <= 1'b1;
            ret_q <= ST_IND_DONE;
            state_q <= ST_HOST;
          end else begin
            tgt_tab_q <= it.table_no;
            state_q <= ST_WORD;
          end
        end
        ST_IND_DONE: begin
          tgt_tab_q <= bcd_to_tab(rd_q);
          state_q <= ST_WORD;
        end
        ST_WORD: begin
          hm_req <= '{we: 1'b0, addr: tab_addr(tgt_str_q, tgt_tab_q, widx_q),
            wdata: 16'h0000};
          hm_req_valid <= 1'b1;
          ret_q <= ST_SHOW;
          state_q <= ST_HOST;
        end
        ST_SHOW: begin
          // Host word passed on untouched; bars draw from it too
          disp_valid <= 1'b1;
          disp <= '{kind: item_q.kind, item: item_idx_q, widx: widx_q,
            data: rd_q};
          if ({1'b0, widx_q} + 5'h01 >= nwords_q) begin
            state_q <= ST_NEXT;
          end else begin
            widx_q <= widx_q + 1'b1;
            state_q <= ST_WORD;
          end
        end
        ST_NEXT: begin
          // Wrap keeps every displayed item refreshed in turn
          item_idx_q <= item_idx_q + 1'b1;
          if (item_idx_q == ITEM_LAST) begin
            ind_num_cnt_q <= 6'h00;
            ind_str_cnt_q <= 6'h00;
          end
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: hw/ssl_pkg.sv
// Shared constants and carrier types for the screen status and memory
// table link. Assumes a single 100 MHz clock and a word-wide host memory.
package ssl_pkg;

  // Host memory words and addressing
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;
  localparam int TAB_W = 8;
  localparam int ITEM_W = 7;

  // Screen data memory: display items low half, init records high half
  localparam int RAM_AW = 8;
  localparam int RAM_DW = 32;
  localparam logic [ITEM_W-1:0] ITEM_LAST = 7'h7f;

  // Notify area layout, relative to its first word
  localparam logic [ADDR_W-1:0] SCREEN_OFS = 16'h0000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 16'h0002;
  localparam int STROBE_BIT = 15;
  localparam logic [WORD_W-1:0] STROBE_MASK = 16'h0001 << STROBE_BIT;
  localparam logic [WORD_W-1:0] BLANK_SCREEN = 16'h0000;

  // Table sizing and per-screen limits
  localparam logic [4:0] STR_MAX_WORDS = 5'h10;
  localparam logic [4:0] NUM_MAX_WORDS = 5'h02;
  localparam logic [5:0] IND_MAX = 6'h32;

  // Strobe hold time before the terminal may clear it
  localparam int CLK_MHZ = 100;
  localparam int STROBE_HOLD_NS = 10000;
  localparam int STROBE_HOLD_CYC = (STROBE_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_W = 11;

  typedef enum logic [1:0] {
    SSL_K_STR,
    SSL_K_NUM,
    SSL_K_BAR,
    SSL_K_ENTRY
  } ssl_kind_t;

  // One display item of the current screen
  typedef struct packed {
    logic valid;
    ssl_kind_t kind;
    logic indirect;
    logic [TAB_W-1:0] table_no;
    logic [4:0] words;
    logic [5:0] digits;
    logic [8:0] spare;
  } ssl_item_t;

  // One power-on initial value record
  typedef struct packed {
    logic valid;
    logic is_str;
    logic [TAB_W-1:0] table_no;
    logic [3:0] widx;
    logic [1:0] spare;
    logic [WORD_W-1:0] value;
  } ssl_init_t;

  // Screen change report
  typedef struct packed {
    logic [WORD_W-1:0] number;
    logic [WORD_W-1:0] parent;
    logic grouped;
  } ssl_scr_t;

  // Host memory request
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } ssl_hreq_t;

  // Word handed to the display side
  typedef struct packed {
    ssl_kind_t kind;
    logic [ITEM_W-1:0] item;
    logic [3:0] widx;
    logic [WORD_W-1:0] data;
  } ssl_disp_t;

endpackage

// File: hw/ssl_tab_ram.sv
// Screen data memory: one write port, one read port with registered data.
// Assumes the loader writes it before data_ready is raised.
`timescale 1ns/1ps
module ssl_tab_ram (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Write side
  input wire logic we,
  input wire logic [ssl_pkg::RAM_AW-1:0] waddr,
  input wire logic [ssl_pkg::RAM_DW-1:0] wdata,
  // Read side
  input wire logic re,
  input wire logic [ssl_pkg::RAM_AW-1:0] raddr,
  output logic [ssl_pkg::RAM_DW-1:0] rdata_q
);
  import ssl_pkg::*;

  logic [RAM_DW-1:0] mem [0:(1<<RAM_AW)-1];

  // Array has no reset so it maps onto block memory
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read, one cycle after re
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (re) begin
      rdata_q <= mem[raddr];
    end
  end

endmodule
